// *** hw/apr_pkg.sv ***
// package: register map, field positions and shared types of the aux pin remap control
// What this block does
// [RULE1] two-bit field picks crystal-output pin: port bit, osc, osc/2, osc/4; code divides clock_i, not osc, for /2 and /4
// [RULE2] that field acts only while internal high-frequency rc osc clocks the system
// [RULE3] port 6 bit 0 fast-drive bit switches that pin to fast drive
// [RULE4] port 3 bit 4 fast-drive bit switches that pin to fast drive
// [RULE5] external-memory fast-drive bit fast-drives the ale, rd and wr strobes
// [RULE6] justify bit clear: upper eight bits high byte, lower two in low[1:0]
// [RULE7] justify bit set: upper two bits in high[1:0], lower eight in low byte
// [RULE8] xram disable bit clear lets on-chip 1024-byte ram serve data accesses
// [RULE9] software writes zero to reserved bit 0 of first register; reads as zero
// [RULE10] keypad remap moves inputs 0-3 to port 4 and 4-7 to port 5
// [RULE11] counter remap moves count input to p4.2, modules 0-1 p4, 2-5 p5
// [RULE12] spi remap moves ss, mosi, miso, sck from p1.4-7 to p5.0-3
// [RULE13] second uart remap moves rx p1.2 to p4.0 and tx p1.3 to p4.1
// [RULE14] software writes zeros to reserved bits 3 to 1 of second register
// [RULE15] data pointer select bit picks pointer 0 when clear, pointer 1 when set
// [RULE16] after reset crystal-output field is 00, pin stays general purpose
// [RULE17] with remap clear, signals stay on original pins, alternates stay ports
package apr_pkg;
  localparam logic [7:0] APR_CLKDRV_ADDR = 8'h8E;
  localparam logic [7:0] APR_REMAP_ADDR = 8'hA2;
  localparam logic [7:0] APR_CLKDRV_RST = 8'h00;
  localparam logic [7:0] APR_REMAP_RST = 8'h00;
  localparam logic [7:0] APR_CLKDRV_WMASK = 8'hFE;
  localparam logic [7:0] APR_REMAP_WMASK = 8'hF1;
  localparam int APR_XOSEL_HI = 7;
  localparam int APR_XOSEL_LO = 6;
  localparam int APR_XOFD_BIT = 5;
  localparam int APR_T0FD_BIT = 4;
  localparam int APR_EMFD_BIT = 3;
  localparam int APR_ADCRJ_BIT = 2;
  localparam int APR_XRAMD_BIT = 1;
  localparam int APR_KBR_BIT = 7;
  localparam int APR_CAR_BIT = 6;
  localparam int APR_SPIR_BIT = 5;
  localparam int APR_U2R_BIT = 4;
  localparam int APR_DPS_BIT = 0;
  localparam logic [1:0] APR_XO_PORT = 2'h0;
  localparam logic [1:0] APR_XO_OSC = 2'h1;
  localparam logic [1:0] APR_XO_DIV2 = 2'h2;
  localparam logic [1:0] APR_XO_DIV4 = 2'h3;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } apr_sfr_t;
  typedef struct packed {
    logic ss;
    logic mosi;
    logic miso;
    logic sck;
  } apr_spi_t;
endpackage

// *** hw/apr_aux_pin_remap_control.sv ***
// module: auxiliary clock-drive and port-remap control registers with pin steering
`timescale 1ns/100ps
`default_nettype none
module apr_aux_pin_remap_control (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire apr_pkg::apr_sfr_t sfr_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic sysclk_is_hf_rc_i,
  input wire logic internal_osc_clock_i,
  input wire logic p60_port_out_i,
  output logic crystal_output_pin_o,
  output logic xtal_out_pin_fast_drive_o,
  output logic timer0_out_pin_fast_drive_o,
  output logic ext_mem_strobe_fast_drive_o,
  input wire logic [9:0] adc_result_i,
  output logic [7:0] adc_result_high_o,
  output logic [7:0] adc_result_low_o,
  output logic onchip_xram_disable_o,
  output logic data_pointer_select_o,
  input wire logic [7:0] p1_pin_i,
  input wire logic [7:0] p2_pin_i,
  input wire logic [3:0] p4_pin_i,
  input wire logic [3:0] p5_pin_i,
  output logic [7:0] keypad_input_o,
  output logic counter_array_ext_input_o,
  input wire logic [5:0] counter_module_out_i,
  input wire logic [5:0] counter_module_oe_i,
  output logic [5:0] counter_module_in_o,
  input wire apr_pkg::apr_spi_t spi_out_i,
  input wire apr_pkg::apr_spi_t spi_oe_i,
  output apr_pkg::apr_spi_t spi_in_o,
  output logic second_uart_rx_o,
  input wire logic second_uart_tx_i,
  input wire logic [3:0] p4_port_out_i,
  input wire logic [3:0] p5_port_out_i,
  input wire logic [7:0] p1_port_out_i,
  output logic [3:0] p4_out_o,
  output logic [3:0] p4_alt_oe_o,
  output logic [3:0] p5_out_o,
  output logic [3:0] p5_alt_oe_o,
  output logic [7:0] p1_out_o,
  output logic [7:0] p1_alt_oe_o
);
  import apr_pkg::*;

  // ********************
  // input synchronisers
  // ********************
  logic [35:0] pin_s1_q;
  logic [35:0] pin_s2_q;
  logic [35:0] pin_raw;
  logic [7:0] p1s;
  logic [7:0] p2s;
  logic [3:0] p4s;
  logic [3:0] p5s;
  // oscillator tap is foreign to clock_i, so it rides the same two stages
  assign pin_raw = {p1_pin_i, p2_pin_i, p4_pin_i, p5_pin_i, sysclk_is_hf_rc_i,
                    internal_osc_clock_i, 10'h000};
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end
  assign p1s = pin_s2_q[35:28];
  assign p2s = pin_s2_q[27:20];
  assign p4s = pin_s2_q[19:16];
  assign p5s = pin_s2_q[15:12];

  // ********************
  // registers
  // ********************
  logic [7:0] clkdrv_q;
  logic [7:0] clkdrv_d;
  logic [7:0] remap_q;
  logic [7:0] remap_d;
  always_comb begin
    clkdrv_d = clkdrv_q;
    remap_d = remap_q;
    if (sfr_i.wr && sfr_i.addr == APR_CLKDRV_ADDR) begin
      clkdrv_d = sfr_i.wdata & APR_CLKDRV_WMASK; // RULE9
    end else if (sfr_i.wr && sfr_i.addr == APR_REMAP_ADDR) begin
      remap_d = sfr_i.wdata & APR_REMAP_WMASK; // RULE14
    end
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clkdrv_q <= APR_CLKDRV_RST; // RULE16
      remap_q <= APR_REMAP_RST;
    end else begin
      clkdrv_q <= clkdrv_d;
      remap_q <= remap_d;
    end
  end
  // unmapped addresses read as zero
  always_comb begin
    if (sfr_i.addr == APR_CLKDRV_ADDR) begin
      sfr_rdata_o = clkdrv_q;
    end else if (sfr_i.addr == APR_REMAP_ADDR) begin
      sfr_rdata_o = remap_q;
    end else begin
      sfr_rdata_o = 8'h00;
    end
  end

  // ********************
  // clock output divider
  // ********************
  // divide is counted on the system clock; the oscillator tap is not used by the divide
  logic [1:0] div_q;
  logic [1:0] div_d;
  logic xo_q;
  logic xo_d;
  logic hf_sel;
  logic osc_s;
  logic [1:0] xo_sel;
  assign hf_sel = pin_s2_q[11];
  // limitation: osc tap above half of clock_i aliases, output is a resample
  assign osc_s = pin_s2_q[10];
  assign xo_sel = clkdrv_q[APR_XOSEL_HI:APR_XOSEL_LO];
  always_comb begin
    div_d = div_q + 2'h1;
    case (xo_sel)
      APR_XO_OSC: xo_d = osc_s; // RULE1
      APR_XO_DIV2: xo_d = div_q[0]; // RULE1
      APR_XO_DIV4: xo_d = div_q[1]; // RULE1
      default: xo_d = p60_port_out_i;
    endcase
    if (!hf_sel) begin
      xo_d = p60_port_out_i; // RULE2
    end
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q <= 2'h0;
      xo_q <= 1'b0;
    end else begin
      div_q <= div_d;
      xo_q <= xo_d;
    end
  end
  assign crystal_output_pin_o = xo_q;

  // ********************
  // drive, adc, memory
  // ********************
  assign xtal_out_pin_fast_drive_o = clkdrv_q[APR_XOFD_BIT]; // RULE3
  assign timer0_out_pin_fast_drive_o = clkdrv_q[APR_T0FD_BIT]; // RULE4
  assign ext_mem_strobe_fast_drive_o = clkdrv_q[APR_EMFD_BIT]; // RULE5
  assign onchip_xram_disable_o = clkdrv_q[APR_XRAMD_BIT]; // RULE8
  assign data_pointer_select_o = remap_q[APR_DPS_BIT]; // RULE15
  logic [15:0] adc_q;
  logic [15:0] adc_d;
  always_comb begin
    if (clkdrv_q[APR_ADCRJ_BIT]) begin
      adc_d = {6'h00, adc_result_i}; // RULE7
    end else begin
      adc_d = {adc_result_i[9:2], 6'h00, adc_result_i[1:0]}; // RULE6
    end
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      adc_q <= 16'h0000;
    end else begin
      adc_q <= adc_d;
    end
  end
  assign adc_result_high_o = adc_q[15:8];
  assign adc_result_low_o = adc_q[7:0];

  // ********************
  // pin remap
  // ********************
  // input muxes read synchronised pins; outputs pass straight to pads
  logic kb;
  logic ca;
  logic sp;
  logic u2;
  assign kb = remap_q[APR_KBR_BIT];
  assign ca = remap_q[APR_CAR_BIT];
  assign sp = remap_q[APR_SPIR_BIT];
  assign u2 = remap_q[APR_U2R_BIT];
  always_comb begin
    keypad_input_o = kb ? {p5s, p4s} : p2s; // RULE10 RULE17
    counter_array_ext_input_o = ca ? p4s[2] : p1s[1]; // RULE11 RULE17
    counter_module_in_o = ca ? {p5s, p4s[1:0]} : p1s[7:2]; // RULE11 RULE17
    spi_in_o = sp ? {p5s[0], p5s[1], p5s[2], p5s[3]} // RULE12
                  : {p1s[4], p1s[5], p1s[6], p1s[7]};
    second_uart_rx_o = u2 ? p4s[0] : p1s[2]; // RULE13 RULE17
    p4_out_o = p4_port_out_i;
    p4_alt_oe_o = 4'h0;
    p5_out_o = p5_port_out_i;
    p5_alt_oe_o = 4'h0;
    p1_out_o = p1_port_out_i;
    p1_alt_oe_o = 8'h00;
    if (ca) begin
      p4_out_o[1:0] = counter_module_out_i[1:0]; // RULE11
      p4_alt_oe_o[1:0] = counter_module_oe_i[1:0];
      p5_out_o = counter_module_out_i[5:2];
      p5_alt_oe_o = counter_module_oe_i[5:2];
    end else begin
      p1_out_o[7:2] = counter_module_out_i; // RULE17
      p1_alt_oe_o[7:2] = counter_module_oe_i;
    end
    if (sp) begin
      p5_out_o = {spi_out_i.sck, spi_out_i.miso, spi_out_i.mosi, spi_out_i.ss}; // RULE12
      p5_alt_oe_o = {spi_oe_i.sck, spi_oe_i.miso, spi_oe_i.mosi, spi_oe_i.ss};
    end else begin
      p1_out_o[7:4] = {spi_out_i.sck, spi_out_i.miso, spi_out_i.mosi, spi_out_i.ss};
      p1_alt_oe_o[7:4] = {spi_oe_i.sck, spi_oe_i.miso, spi_oe_i.mosi, spi_oe_i.ss};
    end
    if (u2) begin
      p4_out_o[1] = second_uart_tx_i; // RULE13
      p4_alt_oe_o[1] = 1'b1;
    end else begin
      p1_out_o[3] = second_uart_tx_i; // RULE17
      p1_alt_oe_o[3] = 1'b1;
    end
  end

  // ********************
  // assertions
  // ********************
  // reserved bits stay clear even if software breaks its side
  AST_RSV0: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE9
    !clkdrv_q[0])
    else $error("reserved bit 0 set");

  AST_RSV31: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE14
    remap_q[3:1] == 3'h0)
    else $error("reserved bits set");

  // clock output
  AST_XO_PORT: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE2
    !hf_sel |=> crystal_output_pin_o == $past(p60_port_out_i))
    else $error("xtal pin not port");

  AST_XO_GPIO: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE1
    (xo_sel == APR_XO_PORT) |=> crystal_output_pin_o == $past(p60_port_out_i))
    else $error("xtal pin not port in gpio mode");

  AST_OSC: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE1
    (hf_sel && xo_sel == APR_XO_OSC) |=> crystal_output_pin_o == $past(osc_s))
    else $error("osc tap wrong");

  AST_DIV2: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE1
    (hf_sel && xo_sel == APR_XO_DIV2) |=> crystal_output_pin_o == $past(div_q[0]))
    else $error("div2 wrong");

  AST_DIV4: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE1
    (hf_sel && xo_sel == APR_XO_DIV4) |=> crystal_output_pin_o == $past(div_q[1]))
    else $error("div4 wrong");

  // register bits reach their outputs one edge after the write
  AST_XOFD: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE3
    (sfr_i.wr && sfr_i.addr == APR_CLKDRV_ADDR)
    |=> xtal_out_pin_fast_drive_o == $past(sfr_i.wdata[APR_XOFD_BIT]))
    else $error("xtal fast drive not written");

  AST_T0FD: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE4
    (sfr_i.wr && sfr_i.addr == APR_CLKDRV_ADDR)
    |=> timer0_out_pin_fast_drive_o == $past(sfr_i.wdata[APR_T0FD_BIT]))
    else $error("timer0 fast drive not written");

  AST_EMFD: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE5
    (sfr_i.wr && sfr_i.addr == APR_CLKDRV_ADDR)
    |=> ext_mem_strobe_fast_drive_o == $past(sfr_i.wdata[APR_EMFD_BIT]))
    else $error("strobe fast drive not written");

  AST_XRAMD: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE8
    (sfr_i.wr && sfr_i.addr == APR_CLKDRV_ADDR)
    |=> onchip_xram_disable_o == $past(sfr_i.wdata[APR_XRAMD_BIT]))
    else $error("xram disable not written");

  AST_WR: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE15
    (sfr_i.wr && sfr_i.addr == APR_REMAP_ADDR)
    |=> data_pointer_select_o == $past(sfr_i.wdata[0]))
    else $error("dps not written");

  // adc justification
  AST_RJ: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE7
    clkdrv_q[APR_ADCRJ_BIT] |=> adc_result_low_o == $past(adc_result_i[7:0]))
    else $error("right justify wrong");

  AST_RJ_HI: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE7
    clkdrv_q[APR_ADCRJ_BIT] |=> adc_result_high_o == {6'h00, $past(adc_result_i[9:8])})
    else $error("right justify high wrong");

  AST_LJ: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE6
    !clkdrv_q[APR_ADCRJ_BIT] |=> adc_result_high_o == $past(adc_result_i[9:2]))
    else $error("left justify wrong");

  AST_LJ_LO: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE6
    !clkdrv_q[APR_ADCRJ_BIT] |=> adc_result_low_o == {6'h00, $past(adc_result_i[1:0])})
    else $error("left justify low wrong");

  // pin steering
  AST_KB: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE10
    kb |-> keypad_input_o[3:0] == p4s)
    else $error("keypad remap wrong");

  AST_KB_OFF: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE17
    !kb |-> keypad_input_o == p2s)
    else $error("keypad not on port 2");

  AST_CA: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE11
    ca |-> counter_array_ext_input_o == p4s[2] && counter_module_in_o[0] == p4s[0])
    else $error("counter remap wrong");

  AST_SPI: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE12
    sp |-> spi_in_o.ss == p5s[0] && p5_out_o[3] == spi_out_i.sck)
    else $error("spi remap wrong");

  AST_U2_ON: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE13
    u2 |-> second_uart_rx_o == p4s[0] && p4_out_o[1] == second_uart_tx_i)
    else $error("uart remap wrong");

  AST_U2: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE17
    !u2 |-> p1_out_o[3] == second_uart_tx_i)
    else $error("uart tx not on p1");
endmodule
`default_nettype wire

// *** tb/apr_pin_partner.sv ***
// partner model: outside world on the remappable port pins
`timescale 1ns/100ps
`default_nettype none
module apr_pin_partner (
  input wire logic [7:0] p1_ext_i,
  input wire logic [3:0] p4_ext_i,
  input wire logic [3:0] p5_ext_i,
  input wire logic [7:0] p1_out_i,
  input wire logic [7:0] p1_oe_i,
  input wire logic [3:0] p4_out_i,
  input wire logic [3:0] p4_oe_i,
  input wire logic [3:0] p5_out_i,
  input wire logic [3:0] p5_oe_i,
  output logic [7:0] p1_pin_o,
  output logic [3:0] p4_pin_o,
  output logic [3:0] p5_pin_o
);
  // a driven bit wins over the outside level, so remapped outputs show on the pad
  assign p1_pin_o = (p1_oe_i & p1_out_i) | (~p1_oe_i & p1_ext_i);
  assign p4_pin_o = (p4_oe_i & p4_out_i) | (~p4_oe_i & p4_ext_i);
  assign p5_pin_o = (p5_oe_i & p5_out_i) | (~p5_oe_i & p5_ext_i);
endmodule
`default_nettype wire

// *** tb/apr_aux_pin_remap_control_tb.sv ***
// testbench: register access, pin steering and clock output of the remap block
`timescale 1ns/100ps
`default_nettype none
module apr_aux_pin_remap_control_tb;
  import apr_pkg::*;
  logic clock_i = 0, rstn_i = 0, sysclk_is_hf_rc_i = 0, internal_osc_clock_i = 0;
  logic p60_port_out_i = 1, second_uart_tx_i = 1;
  logic crystal_output_pin_o, xtal_out_pin_fast_drive_o, timer0_out_pin_fast_drive_o;
  logic ext_mem_strobe_fast_drive_o, onchip_xram_disable_o, data_pointer_select_o;
  logic counter_array_ext_input_o, second_uart_rx_o;
  apr_sfr_t sfr_i = '0;
  apr_spi_t spi_out_i = '0, spi_oe_i = '0, spi_in_o;
  logic [7:0] sfr_rdata_o, adc_result_high_o, adc_result_low_o, keypad_input_o;
  logic [9:0] adc_result_i = 10'h2C5;
  logic [7:0] p1_pin_i, p1_ext = 8'h96, p2_pin_i = 8'hA5, p1_port_out_i = 8'h00;
  logic [7:0] p1_out_o, p1_alt_oe_o;
  logic [3:0] p4_pin_i, p5_pin_i, p4_ext = 4'h3, p5_ext = 4'hC;
  logic [3:0] p4_port_out_i = 4'h0, p5_port_out_i = 4'h0;
  logic [3:0] p4_out_o, p4_alt_oe_o, p5_out_o, p5_alt_oe_o;
  logic [5:0] counter_module_out_i = '0, counter_module_oe_i = '0, counter_module_in_o;
  // software keeps reserved bits zero on every write to the two registers
  logic [31:0] rows [6] = '{32'h8EFEFEF0, 32'h8E202080, 32'hA2F1F188, 32'h8E1A1A78,
    32'hA2000070, 32'h55FF0070};
  logic [7:0] bits_seen;
  assign bits_seen = {xtal_out_pin_fast_drive_o, timer0_out_pin_fast_drive_o,
    ext_mem_strobe_fast_drive_o, onchip_xram_disable_o, data_pointer_select_o, 3'h0};
  int errors = 0, checked = 0, n;
  always #12.5 clock_i = ~clock_i;
  apr_aux_pin_remap_control i_apr_aux_pin_remap_control (.clock_i, .rstn_i, .sfr_i,
    .sfr_rdata_o, .sysclk_is_hf_rc_i, .internal_osc_clock_i, .p60_port_out_i,
    .crystal_output_pin_o, .xtal_out_pin_fast_drive_o, .timer0_out_pin_fast_drive_o,
    .ext_mem_strobe_fast_drive_o, .adc_result_i, .adc_result_high_o, .adc_result_low_o,
    .onchip_xram_disable_o, .data_pointer_select_o, .p1_pin_i, .p2_pin_i, .p4_pin_i,
    .p5_pin_i, .keypad_input_o, .counter_array_ext_input_o, .counter_module_out_i,
    .counter_module_oe_i, .counter_module_in_o, .spi_out_i, .spi_oe_i, .spi_in_o,
    .second_uart_rx_o, .second_uart_tx_i, .p4_port_out_i, .p5_port_out_i, .p1_port_out_i,
    .p4_out_o, .p4_alt_oe_o, .p5_out_o, .p5_alt_oe_o, .p1_out_o, .p1_alt_oe_o);
  apr_pin_partner i_apr_pin_partner (.p1_ext_i(p1_ext), .p4_ext_i(p4_ext),
    .p5_ext_i(p5_ext), .p1_out_i(p1_out_o), .p1_oe_i(p1_alt_oe_o), .p4_out_i(p4_out_o),
    .p4_oe_i(p4_alt_oe_o), .p5_out_i(p5_out_o), .p5_oe_i(p5_alt_oe_o),
    .p1_pin_o(p1_pin_i), .p4_pin_o(p4_pin_i), .p5_pin_o(p5_pin_i));
  // ********************
  // tasks
  // ********************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    sfr_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock_i);
    sfr_i = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock_i);
    sfr_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    #1;
    chk(sfr_rdata_o, exp);
  endtask
  // pins pass two sync stages before they reach the outputs
  task automatic settle();
    repeat (4) @(negedge clock_i);
  endtask
  task automatic edges(output int cnt);
    logic prev;
    cnt = 0;
    prev = crystal_output_pin_o;
    repeat (16) begin
      @(negedge clock_i);
      if (crystal_output_pin_o !== prev) cnt++;
      prev = crystal_output_pin_o;
    end
  endtask
  task automatic summarize();
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #(25 * 4000);
    errors++;
    summarize();
  end
  // ********************
  // main sequence
  // ********************
  initial begin
    repeat (4) @(negedge clock_i);
    rstn_i = 1;
    rd(APR_CLKDRV_ADDR, APR_CLKDRV_RST);
    rd(APR_REMAP_ADDR, APR_REMAP_RST);
    settle();
    chk({7'h00, crystal_output_pin_o}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      wr(rows[i][31:24], rows[i][23:16]);
      rd(rows[i][31:24], rows[i][15:8]);
      chk(bits_seen, rows[i][7:0]);
    end
    wr(APR_CLKDRV_ADDR, 8'h00);
    repeat (2) @(negedge clock_i);
    chk(adc_result_high_o, 8'hB1);
    chk(adc_result_low_o, 8'h01);
    wr(APR_CLKDRV_ADDR, 8'h04);
    repeat (2) @(negedge clock_i);
    chk(adc_result_high_o, 8'h02);
    chk(adc_result_low_o, 8'hC5);
    wr(APR_REMAP_ADDR, 8'h00);
    settle();
    chk(keypad_input_o, 8'hA5);
    chk({2'h0, counter_array_ext_input_o, second_uart_rx_o, spi_in_o}, 8'h39);
    chk({2'h0, counter_module_in_o}, 8'h27);
    second_uart_tx_i = 0;
    wr(APR_REMAP_ADDR, 8'hF0);
    settle();
    chk(keypad_input_o, 8'hC1);
    chk({2'h0, counter_array_ext_input_o, second_uart_rx_o, spi_in_o}, 8'h13);
    chk({6'h00, p4_alt_oe_o[1], p4_out_o[1]}, 8'h02);
    chk({2'h0, counter_module_in_o}, 8'h31);
    wr(APR_CLKDRV_ADDR, 8'h40);
    settle();
    chk({7'h00, crystal_output_pin_o}, 8'h01);
    sysclk_is_hf_rc_i = 1;
    settle();
    chk({7'h00, crystal_output_pin_o}, 8'h00);
    internal_osc_clock_i = 1;
    settle();
    chk({7'h00, crystal_output_pin_o}, 8'h01);
    wr(APR_CLKDRV_ADDR, 8'h80);
    settle();
    edges(n);
    chk(8'(n), 8'd16);
    wr(APR_CLKDRV_ADDR, 8'hC0);
    settle();
    edges(n);
    chk(8'(n), 8'd8);
    p60_port_out_i = 0;
    wr(APR_CLKDRV_ADDR, 8'h00);
    settle();
    chk({7'h00, crystal_output_pin_o}, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
